// file: include/aof_pkg.sv
package aof_pkg;

  // Sample word layout.
  localparam int CODE_W = 12;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [11:0] CODE_MIN = 12'h000;
  localparam logic signed [13:0] LEVEL_MAX = 14'sh07ff;
  localparam logic signed [13:0] LEVEL_MIN = -14'sh0800;

  // Output-select strap levels.
  typedef enum logic [1:0] {
    AOF_MODE_FULL = 2'h0,
    AOF_MODE_DEMUX_SIM = 2'h1,
    AOF_MODE_DEMUX_INT = 2'h2,
    AOF_MODE_LVDS = 2'h3
  } aof_out_mode_t;

  // Format strap levels.
  typedef enum logic [1:0] {
    AOF_FMT_OB_DCS_OFF = 2'h0,
    AOF_FMT_OB_DCS_ON = 2'h1,
    AOF_FMT_TC_DCS_ON = 2'h2,
    AOF_FMT_TC_DCS_OFF = 2'h3
  } aof_fmt_strap_t;

  // Timing.
  localparam int CLK_SYS_PS = 5000;
  localparam int ENC_MAX_RATE_MSPS = 250;
  localparam int ENC_MIN_HALF_PS = 1900;
  localparam int ENC_MIN_HALF_CYC =
    (ENC_MIN_HALF_PS + CLK_SYS_PS - 1) / CLK_SYS_PS;
  localparam int ENC_MIN_RATE_MSPS = 1;
  localparam int ENC_STOP_NS = 1000 / ENC_MIN_RATE_MSPS;
  localparam int ENC_STOP_CYC = ENC_STOP_NS * 1000 / CLK_SYS_PS;
  localparam int LOCK_CYCLES = 100;
  localparam int PIPE_LATENCY_DEF = 5;
  localparam int HOST_ENC_HALF_DEF = 5;

  // Controller register map, byte offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STS_A_BIT = 0;
  localparam int STS_B_BIT = 1;
  localparam int STS_OVF_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // Returns {overflow, code} for a level given in LSBs around midscale.
  function automatic logic [12:0] fmt_code(
    input logic signed [13:0] lvl,
    input logic twos
  );
    logic [11:0] c;
    logic ovf;
    ovf = (lvl > LEVEL_MAX) || (lvl < LEVEL_MIN);
    if (lvl > LEVEL_MAX) begin
      c = CODE_MAX;
    end else if (lvl < LEVEL_MIN) begin
      c = CODE_MIN;
    end else begin
      c = lvl[11:0] ^ CODE_MID;
    end
    fmt_code = {ovf, c ^ {twos, 11'h000}};
  endfunction

endpackage

// file: include/aof_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aof_link_if;
  logic encode_in_p;
  logic encode_in_n;
  logic [11:0] sample_code_a;
  logic [11:0] sample_code_b;
  logic overflow_bus_a;
  logic overflow_bus_b;
  logic forwarded_clock_bus_a;
  logic forwarded_clock_bus_b;
  logic [11:0] lvds_code_p;
  logic [11:0] lvds_code_n;
  logic overflow_flag_p;
  logic overflow_flag_n;
  logic forwarded_sample_clock_p;
  logic forwarded_sample_clock_n;

  modport device (
    input encode_in_p, encode_in_n,
    output sample_code_a, sample_code_b, overflow_bus_a, overflow_bus_b,
    output forwarded_clock_bus_a, forwarded_clock_bus_b,
    output lvds_code_p, lvds_code_n, overflow_flag_p, overflow_flag_n,
    output forwarded_sample_clock_p, forwarded_sample_clock_n
  );

  modport host (
    output encode_in_p, encode_in_n,
    input sample_code_a, sample_code_b, overflow_bus_a, overflow_bus_b,
    input forwarded_clock_bus_a, forwarded_clock_bus_b,
    input lvds_code_p, lvds_code_n, overflow_flag_p, overflow_flag_n,
    input forwarded_sample_clock_p, forwarded_sample_clock_n
  );
endinterface
`default_nettype wire

// file: src/aof_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module aof_device_end #(
  parameter int LATENCY = aof_pkg::PIPE_LATENCY_DEF
) (
  // Link to the capturing logic
  aof_link_if.device link,
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Static straps
  input wire logic [1:0] i_strap_out_sel,
  input wire logic [1:0] i_strap_format,
  // Converted input level in LSBs around midscale
  input wire logic signed [13:0] i_input_level,
  // Status
  output logic o_locked,
  output logic o_dcs_on
);

  localparam logic [8:0] STOP_CYC = 9'(aof_pkg::ENC_STOP_CYC);
  localparam logic [6:0] LOCK_CYC = 7'(aof_pkg::LOCK_CYCLES);

  // Pin synchronisers; the first stage feeds only the second.
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {i_strap_out_sel, i_strap_format,
                     link.encode_in_p, link.encode_in_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire aof_pkg::aof_out_mode_t mode = aof_pkg::aof_out_mode_t'(pin_s2_reg[5:4]);
  wire aof_pkg::aof_fmt_strap_t fmt =
    aof_pkg::aof_fmt_strap_t'(pin_s2_reg[3:2]);
  wire enc_lvl = pin_s2_reg[1] & ~pin_s2_reg[0];
  wire dcs_on = (fmt == aof_pkg::AOF_FMT_OB_DCS_ON) ||
                (fmt == aof_pkg::AOF_FMT_TC_DCS_ON);
  wire twos = fmt[1];
  wire is_demux = (mode == aof_pkg::AOF_MODE_DEMUX_SIM) ||
                  (mode == aof_pkg::AOF_MODE_DEMUX_INT);
  wire is_full = (mode == aof_pkg::AOF_MODE_FULL);
  wire is_lvds = (mode == aof_pkg::AOF_MODE_LVDS);

  // Encode edge and period tracking.
  logic enc_d_reg;
  logic [8:0] per_cnt_reg;
  logic [8:0] period_reg;
  logic [6:0] lock_cnt_reg;
  wire enc_rise = enc_lvl & ~enc_d_reg;
  // A gap as long as the slowest legal period, or longer, means the clock stopped.
  wire stopped = per_cnt_reg >= STOP_CYC;
  wire [8:0] per_cnt_next = enc_rise ? 9'h001 :
                            (stopped ? per_cnt_reg : per_cnt_reg + 9'h001);
  wire [6:0] lock_cnt_next =
    stopped ? 7'h00 :
    ((enc_rise && lock_cnt_reg != LOCK_CYC) ?
     lock_cnt_reg + 7'h01 : lock_cnt_reg);
  wire locked = dcs_on ? (lock_cnt_reg == LOCK_CYC) : ~stopped;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enc_d_reg <= 1'b0;
      per_cnt_reg <= STOP_CYC;
      period_reg <= 9'h000;
      lock_cnt_reg <= 7'h00;
    end else begin
      enc_d_reg <= enc_lvl;
      per_cnt_reg <= per_cnt_next;
      period_reg <= enc_rise ? per_cnt_reg : period_reg;
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  // Internal encode clock. With the stabilizer the incoming falling edge
  // is ignored and the high phase lasts half the measured period, so the
  // input duty cycle does not reach the sampling logic.
  logic int_clk_reg;
  logic int_d_reg;
  logic [8:0] hi_cnt_reg;
  wire [8:0] half = (period_reg >> 1) | {8'h00, period_reg[8:1] == 8'h00};
  wire dcs_clk_next = enc_rise ? 1'b1 :
                      (int_clk_reg && hi_cnt_reg >= half) ? 1'b0 :
                      int_clk_reg;
  wire int_clk_next = dcs_on ? dcs_clk_next : enc_lvl;
  wire [8:0] hi_cnt_next = enc_rise ? 9'h001 :
                           (hi_cnt_reg == 9'h1ff ? hi_cnt_reg :
                            hi_cnt_reg + 9'h001);
  // Ticks during relock are dropped so no unsettled word leaves.
  wire tick = int_clk_reg & ~int_d_reg & locked;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_clk_reg <= 1'b0;
      int_d_reg <= 1'b0;
      hi_cnt_reg <= 9'h000;
    end else begin
      int_clk_reg <= int_clk_next;
      int_d_reg <= int_clk_reg;
      hi_cnt_reg <= hi_cnt_next;
    end
  end

  // Pipeline: one stage per sampling edge.
  logic [12:0] pipe_reg [LATENCY];
  wire [12:0] word = pipe_reg[LATENCY - 1];
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_reg[i] <= 13'h0000;
      end
    end else if (tick) begin
      pipe_reg[0] <= aof_pkg::fmt_code(i_input_level, twos);
      for (int i = 1; i < LATENCY; i++) begin
        pipe_reg[i] <= pipe_reg[i - 1];
      end
    end
  end

  // Forwarded clocks leave two cycles after the tick and data one cycle
  // after them, so the receiver never sees both change on one edge.
  logic tick_d_reg;
  logic tick_dd_reg;
  logic slot_a_reg;
  logic clk_full_reg;
  logic clk_half_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_d_reg <= 1'b0;
      tick_dd_reg <= 1'b0;
      slot_a_reg <= 1'b0;
      clk_full_reg <= 1'b0;
      clk_half_reg <= 1'b0;
    end else begin
      tick_d_reg <= tick;
      tick_dd_reg <= tick_d_reg;
      clk_full_reg <= int_clk_reg & locked;
      if (tick) begin
        slot_a_reg <= ~slot_a_reg;
        clk_half_reg <= ~slot_a_reg;
      end
    end
  end

  // Bus registers.
  logic [12:0] bus_a_reg;
  logic [12:0] bus_b_reg;
  logic [12:0] pend_a_reg;
  logic [12:0] pend_b_reg;
  logic [12:0] lvds_reg;
  logic fwd_a_reg;
  logic fwd_b_reg;
  logic fwd_lvds_reg;
  // After the toggle, slot_a_reg high means the word belongs to bus A.
  wire upd = tick_dd_reg;
  wire in_a = slot_a_reg;
  wire sim = (mode == aof_pkg::AOF_MODE_DEMUX_SIM);
  wire [12:0] bus_a_next =
    !upd ? bus_a_reg :
    is_full ? word :
    (is_demux && !sim && in_a) ? word :
    (sim && in_a) ? pend_a_reg : bus_a_reg;
  wire [12:0] bus_b_next =
    !upd ? bus_b_reg :
    (is_demux && !sim && !in_a) ? word :
    (sim && in_a) ? pend_b_reg : bus_b_reg;
  wire [12:0] pend_a_next = (upd && sim && in_a) ? word : pend_a_reg;
  wire [12:0] pend_b_next = (upd && sim && !in_a) ? word : pend_b_reg;
  wire [12:0] lvds_next = (upd && is_lvds) ? word : lvds_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_a_reg <= 13'h0000;
      bus_b_reg <= 13'h0000;
      pend_a_reg <= 13'h0000;
      pend_b_reg <= 13'h0000;
      lvds_reg <= 13'h0000;
      fwd_a_reg <= 1'b0;
      fwd_b_reg <= 1'b0;
      fwd_lvds_reg <= 1'b0;
    end else begin
      bus_a_reg <= bus_a_next;
      bus_b_reg <= bus_b_next;
      pend_a_reg <= pend_a_next;
      pend_b_reg <= pend_b_next;
      lvds_reg <= lvds_next;
      // In simultaneous mode clock B falls as clock A rises.
      fwd_a_reg <= is_full ? clk_full_reg :
                   (is_demux ? clk_half_reg : 1'b0);
      fwd_b_reg <= is_demux ? ~clk_half_reg : 1'b0;
      fwd_lvds_reg <= is_lvds ? clk_full_reg : 1'b0;
    end
  end

  // Pins.
  assign link.sample_code_a = bus_a_reg[11:0];
  assign link.sample_code_b = bus_b_reg[11:0];
  assign link.overflow_bus_a = bus_a_reg[12];
  assign link.overflow_bus_b = bus_b_reg[12];
  assign link.forwarded_clock_bus_a = fwd_a_reg;
  assign link.forwarded_clock_bus_b = fwd_b_reg;
  assign link.lvds_code_p = lvds_reg[11:0];
  assign link.lvds_code_n = ~lvds_reg[11:0];
  assign link.overflow_flag_p = lvds_reg[12];
  assign link.overflow_flag_n = ~lvds_reg[12];
  assign link.forwarded_sample_clock_p = fwd_lvds_reg;
  assign link.forwarded_sample_clock_n = ~fwd_lvds_reg;
  assign o_locked = locked;
  assign o_dcs_on = dcs_on;

endmodule
`default_nettype wire

// file: src/aof_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module aof_host_end #(
  parameter int ENC_HALF = aof_pkg::HOST_ENC_HALF_DEF
) (
  // Link to the converter
  aof_link_if.host link,
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq,
  // Captured samples
  output logic [12:0] o_word_a,
  output logic o_valid_a,
  output logic [12:0] o_word_b,
  output logic o_valid_b
);

  // Encode clock by divider; half period never below the settling floor.
  localparam int HALF = (ENC_HALF < aof_pkg::ENC_MIN_HALF_CYC) ?
                        aof_pkg::ENC_MIN_HALF_CYC : ENC_HALF;
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
  logic [2:0] ctrl_reg;
  logic [7:0] div_reg;
  logic enc_reg;
  wire run = ctrl_reg[aof_pkg::CTRL_RUN_BIT];
  wire div_end = (div_reg == HALF_LAST);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 8'h00;
      enc_reg <= 1'b0;
    end else begin
      div_reg <= (!run || div_end) ? 8'h00 : div_reg + 8'h01;
      enc_reg <= run ? (enc_reg ^ div_end) : 1'b0;
    end
  end
  assign link.encode_in_p = enc_reg;
  assign link.encode_in_n = ~enc_reg;

  // Two-flop synchronisers for every converter pin except the negative halves of the pairs.
  logic [41:0] s1_reg;
  logic [41:0] s2_reg;
  logic [2:0] ck_d_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= 42'h0;
      s2_reg <= 42'h0;
      ck_d_reg <= 3'h0;
    end else begin
      s1_reg <= {link.forwarded_clock_bus_a, link.forwarded_clock_bus_b,
                 link.forwarded_sample_clock_p, link.overflow_bus_a,
                 link.overflow_bus_b, link.overflow_flag_p,
                 link.sample_code_a, link.sample_code_b, link.lvds_code_p};
      s2_reg <= s1_reg;
      ck_d_reg <= s2_reg[41:39];
    end
  end

  wire aof_pkg::aof_out_mode_t mode =
    aof_pkg::aof_out_mode_t'(ctrl_reg[2:1]);
  wire [2:0] ck = s2_reg[41:39];
  wire [2:0] ck_fall = ck_d_reg & ~ck;
  wire [2:0] ck_rise = ~ck_d_reg & ck;
  wire is_lvds = (mode == aof_pkg::AOF_MODE_LVDS);
  wire cap_a = is_lvds ? ck_fall[0] : ck_fall[2];
  wire cap_b = (mode == aof_pkg::AOF_MODE_DEMUX_INT) ? ck_fall[1] :
               (mode == aof_pkg::AOF_MODE_DEMUX_SIM) ? ck_rise[1] :
               1'b0;
  wire [12:0] in_a = is_lvds ? {s2_reg[36], s2_reg[11:0]} :
                               {s2_reg[38], s2_reg[35:24]};
  wire [12:0] in_b = {s2_reg[37], s2_reg[23:12]};

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word_a <= 13'h0000;
      o_word_b <= 13'h0000;
      o_valid_a <= 1'b0;
      o_valid_b <= 1'b0;
    end else begin
      o_word_a <= cap_a ? in_a : o_word_a;
      o_word_b <= cap_b ? in_b : o_word_b;
      o_valid_a <= cap_a;
      o_valid_b <= cap_b;
    end
  end

  // Register slave: one wait cycle per access.
  logic ack_reg;
  logic [2:0] sts_reg;
  logic [2:0] mask_reg;
  wire req = i_avs_read | i_avs_write;
  // Writes land at the edge that ends the wait, never earlier.
  wire wr = i_avs_write & ack_reg;
  wire wr_ctrl = wr && (i_avs_address == aof_pkg::REG_CTRL);
  wire wr_sts = wr && (i_avs_address == aof_pkg::REG_STATUS);
  wire wr_mask = wr && (i_avs_address == aof_pkg::REG_MASK);
  wire [2:0] sts_set = {(cap_a & in_a[12]) | (cap_b & in_b[12]),
                        cap_b, cap_a};
  // A new event in the clearing cycle stays set.
  wire [2:0] sts_next = (sts_reg & ~(wr_sts ? i_avs_writedata[2:0] : 3'h0))
                        | sts_set;
  wire [31:0] rd_mux =
    (i_avs_address == aof_pkg::REG_CTRL) ? {29'h0, ctrl_reg} :
    (i_avs_address == aof_pkg::REG_STATUS) ? {29'h0, sts_reg} :
    (i_avs_address == aof_pkg::REG_MASK) ? {29'h0, mask_reg} :
    (i_avs_address == aof_pkg::REG_DATA) ?
      {3'h0, o_word_b, 3'h0, o_word_a} : 32'h0;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
      ctrl_reg <= aof_pkg::CTRL_RESET;
      mask_reg <= aof_pkg::MASK_RESET;
      sts_reg <= 3'h0;
      o_avs_readdata <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      ctrl_reg <= wr_ctrl ? i_avs_writedata[2:0] : ctrl_reg;
      mask_reg <= wr_mask ? i_avs_writedata[2:0] : mask_reg;
      sts_reg <= sts_next;
      o_avs_readdata <= (i_avs_read & ~ack_reg) ? rd_mux : o_avs_readdata;
    end
  end

  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_irq = |(sts_reg & mask_reg);

endmodule
`default_nettype wire

// file: test/aof_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aof_assertions (
  // Clock, reset and bus mode strap
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [1:0] i_strap_out_sel,
  // Link signals
  input wire logic encode_in_p,
  input wire logic [11:0] sample_code_a,
  input wire logic [11:0] sample_code_b,
  input wire logic overflow_bus_a,
  input wire logic forwarded_clock_bus_a,
  input wire logic forwarded_clock_bus_b,
  input wire logic [11:0] lvds_code_p,
  input wire logic [11:0] lvds_code_n,
  input wire logic overflow_flag_p,
  input wire logic overflow_flag_n,
  input wire logic forwarded_sample_clock_p
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Saturates so a long stop never wraps into a false young age.
  logic [7:0] enc_age_reg;
  wire is_full = i_strap_out_sel == 2'h0;
  wire is_sim = i_strap_out_sel == 2'h1;
  wire is_int = i_strap_out_sel == 2'h2;
  wire is_lvds = i_strap_out_sel == 2'h3;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enc_age_reg <= 8'hff;
    end else if ($rose(encode_in_p)) begin
      enc_age_reg <= 8'h00;
    end else if (enc_age_reg != 8'hff) begin
      enc_age_reg <= enc_age_reg + 8'h01;
    end
  end
  property p_a_after_clk;
    $changed(sample_code_a) |->
      $past(forwarded_clock_bus_a) && !$past(forwarded_clock_bus_a, 2);
  endproperty
  a_a_after_clk: assert property (p_a_after_clk)
    else $error("bus A changed without a clock A rise");
  property p_b_int;
    is_int && $changed(sample_code_b) |->
      $past(forwarded_clock_bus_b) && !$past(forwarded_clock_bus_b, 2);
  endproperty
  a_b_int: assert property (p_b_int)
    else $error("interleaved bus B changed without a clock B rise");
  property p_b_sim;
    is_sim && $changed(sample_code_b) |->
      !$past(forwarded_clock_bus_b) && $past(forwarded_clock_bus_b, 2);
  endproperty
  a_b_sim: assert property (p_b_sim)
    else $error("simultaneous bus B changed without a clock B fall");
  property p_lvds_after_clk;
    $changed(lvds_code_p) |-> $past(forwarded_sample_clock_p) &&
      !$past(forwarded_sample_clock_p, 2);
  endproperty
  a_lvds_after_clk: assert property (p_lvds_after_clk)
    else $error("serial pair data changed without a clock rise");
  property p_lvds_pairs;
    lvds_code_n == ~lvds_code_p && overflow_flag_n == !overflow_flag_p;
  endproperty
  a_lvds_pairs: assert property (p_lvds_pairs)
    else $error("differential pair halves not complementary");
  property p_ovf_sat;
    overflow_bus_a |->
      sample_code_a inside {12'hfff, 12'h000, 12'h7ff, 12'h800};
  endproperty
  a_ovf_sat: assert property (p_ovf_sat)
    else $error("overflow with an unsaturated code");
  property p_full_b_idle;
    is_full |-> !forwarded_clock_bus_b && sample_code_b == 12'h000;
  endproperty
  a_full_b_idle: assert property (p_full_b_idle)
    else $error("bus B active in full rate mode");
  property p_lvds_cmos_idle;
    is_lvds |-> !forwarded_clock_bus_a && sample_code_a == 12'h000;
  endproperty
  a_lvds_cmos_idle: assert property (p_lvds_cmos_idle)
    else $error("bus A active in serial pair mode");
  property p_clk_follows_enc;
    $rose(forwarded_clock_bus_a) |-> enc_age_reg <= 8'h07;
  endproperty
  a_clk_follows_enc: assert property (p_clk_follows_enc)
    else $error("clock A rose long after any encode rise");
endmodule
`default_nettype wire

// file: test/adc_output_formatter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
      n_mismatch++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module adc_output_formatter_bench;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] fmt;
    logic signed [13:0] lvl;
    logic [12:0] exp;
  } aof_row_t;
  aof_row_t rows [8] = '{
    '{2'h0, 2'h0, 14'sh0000, 13'h0800}, '{2'h0, 2'h1, 14'sh07ff, 13'h0fff},
    '{2'h1, 2'h2, 14'sh3800, 13'h0800}, '{2'h2, 2'h3, 14'sh0bb8, 13'h17ff},
    '{2'h3, 2'h0, 14'sh3448, 13'h1000}, '{2'h0, 2'h3, 14'sh0000, 13'h0000},
    '{2'h1, 2'h1, 14'sh0001, 13'h0801}, '{2'h2, 2'h2, 14'sh3fff, 13'h0fff}};
  logic i_clk_sys, i_rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic locked, dcs_on, valid_a, valid_b;
  logic [1:0] strap_out_sel, strap_format;
  logic signed [13:0] input_level;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [12:0] word_a, word_b;
  int n_mismatch, tests_run, cyc;
  aof_link_if aof_link_if_i ();
  aof_device_end aof_device_end_i (.link(aof_link_if_i.device),
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_strap_out_sel(strap_out_sel), .i_strap_format(strap_format),
    .i_input_level(input_level), .o_locked(locked), .o_dcs_on(dcs_on));
  aof_host_end aof_host_end_i (.link(aof_link_if_i.host),
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .o_irq(irq), .o_word_a(word_a),
    .o_valid_a(valid_a), .o_word_b(word_b), .o_valid_b(valid_b));
  aof_assertions aof_assertions_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_strap_out_sel(strap_out_sel),
    .encode_in_p(aof_link_if_i.encode_in_p),
    .sample_code_a(aof_link_if_i.sample_code_a),
    .sample_code_b(aof_link_if_i.sample_code_b),
    .overflow_bus_a(aof_link_if_i.overflow_bus_a),
    .forwarded_clock_bus_a(aof_link_if_i.forwarded_clock_bus_a),
    .forwarded_clock_bus_b(aof_link_if_i.forwarded_clock_bus_b),
    .lvds_code_p(aof_link_if_i.lvds_code_p),
    .lvds_code_n(aof_link_if_i.lvds_code_n),
    .overflow_flag_p(aof_link_if_i.overflow_flag_p),
    .overflow_flag_n(aof_link_if_i.overflow_flag_n),
    .forwarded_sample_clock_p(aof_link_if_i.forwarded_sample_clock_p));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Waitrequest and read data are taken at the rising edge ending the wait.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    @(posedge i_clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    while (w && n < 50) begin
      @(posedge i_clk_sys);
      n++;
      w = avs_waitrequest !== 1'b0;
      rd = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic wait_for(input int which);
    logic hit;
    hit = 1'b0;
    cyc = 0;
    while (!hit && cyc < 4000) begin
      @(negedge i_clk_sys);
      cyc++;
      hit = which == 0 ? valid_a === 1'b1 :
            which == 1 ? valid_b === 1'b1 : locked === 1'b1;
    end
    if (!hit) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  initial begin
    i_rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {strap_out_sel, strap_format, input_level} = '0;
    n_mismatch = 0;
    tests_run = 0;
    foreach (rows[i]) begin
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      strap_out_sel <= rows[i].mode;
      strap_format <= rows[i].fmt;
      input_level <= rows[i].lvl;
      repeat (16) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      bus(1'b1, aof_pkg::REG_CTRL, {29'h0, rows[i].mode, 1'b1});
      wait_for(2);
      `CHK("dcs_on", rows[i].fmt inside {2'h1, 2'h2}, dcs_on);
      `CHK("slow_lock", rows[i].fmt inside {2'h1, 2'h2}, cyc > 500);
      repeat (8) wait_for(0);
      `CHK("word_a", rows[i].exp, word_a);
      if (rows[i].mode inside {2'h1, 2'h2}) begin
        wait_for(1);
        `CHK("word_b", rows[i].exp, word_b);
      end
      bus(1'b0, aof_pkg::REG_STATUS, 32'h0);
      `CHK("status", {rows[i].exp[12], 1'b1}, {rd[2], rd[0]});
      bus(1'b0, aof_pkg::REG_DATA, 32'h0);
      `CHK("data", rows[i].exp, rd[12:0]);
    end
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rd);
    bus(1'b0, aof_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h5, rd);
    bus(1'b1, aof_pkg::REG_MASK, 32'h1);
    @(negedge i_clk_sys);
    `CHK("irq_on", 1'b1, irq);
    bus(1'b1, aof_pkg::REG_MASK, 32'h0);
    @(negedge i_clk_sys);
    `CHK("irq_masked", 1'b0, irq);
    // Captures must drain after the stop before a clear can stick.
    bus(1'b1, aof_pkg::REG_MASK, 32'h7);
    bus(1'b1, aof_pkg::REG_CTRL, 32'h0);
    repeat (600) @(posedge i_clk_sys);
    `CHK("stopped_lock", 1'b0, locked);
    bus(1'b1, aof_pkg::REG_STATUS, 32'h7);
    bus(1'b0, aof_pkg::REG_STATUS, 32'h0);
    `CHK("status_clr", 32'h0, rd);
    @(negedge i_clk_sys);
    `CHK("irq_off", 1'b0, irq);
    end_of_test();
  end
endmodule
`default_nettype wire
